/* File: src/cma_core.sv */
// Overview of operation
// - Narrow mode keeps only the low 16 bits of every effective address.
// - Upper register halves hold any value while lower halves address memory.
// - Narrow-mode post-increment or pre-decrement carries or borrows into the upper half.
// - Narrow vectors start at zero, one 16-bit branch address each.
// - Narrow memory-indirect branches read a 16-bit target from the low 256 bytes.
// - Wide mode reaches 16 Mbytes; upper halves extend 32-bit address registers.
// - Wide vectors are 32-bit entries at zero; low 24 bits give the target.
// - Wide memory-indirect operand is a longword whose top byte counts as zero.
// - Calls push the PC, exceptions push PC and condition codes, never extended control state.
// - The core runs narrow or wide, chosen by the mode pin.
// - Sixteen 16-bit registers, also sixteen bytes or eight 32-bit registers.
// - Multiplies take 12 or 20 states unsigned, 13 or 21 signed.
// - Frequent instructions finish in one state.
// - Sleep enters power-down and selects the core clock speed.
// - Accumulator register and its four instructions are absent.
`timescale 1ns/10ps
`default_nettype none
`include "cma_consts.svh"

module cma_core
	import cma_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Mode strap
	input wire logic modePin,
	// Command port
	input wire logic cmdValid,
	input wire cma_pkg::cma_cmd_t cmd,
	output logic cmdReady,
	output logic done,
	output logic illegalOp,
	output logic [31:0] result,
	// Memory port
	output cma_pkg::cma_mem_req_t memReq,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	// Power and status
	input wire logic wake,
	output logic powerDown,
	output logic [1:0] clkSel,
	output logic modeWide,
	output logic [31:0] pc
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] maskAddr(input logic wide, input logic [31:0] a);
		maskAddr = a & (wide ? `CMA_WIDE_ADDR_MASK : `CMA_NARROW_ADDR_MASK);
	endfunction

	// Byte index bit 3 picks the low byte; word index bit 3 picks the upper half
	function automatic logic [31:0] getSized(input logic [31:0] v, input logic [3:0] idx, input cma_size_t sz);
		unique case (sz)
			CMA_SZ_B: getSized = {24'h000000, idx[3] ? v[7:0] : v[15:8]};
			CMA_SZ_W: getSized = {16'h0000, idx[3] ? v[31:16] : v[15:0]};
			default: getSized = v;
		endcase
	endfunction

	function automatic logic [31:0] putSized(input logic [31:0] v, input logic [3:0] idx, input cma_size_t sz,
		input logic [31:0] d);
		unique case (sz)
			CMA_SZ_B: putSized = idx[3] ? {v[31:8], d[7:0]} : {v[31:16], d[7:0], v[7:0]};
			CMA_SZ_W: putSized = idx[3] ? {d[15:0], v[15:0]} : {v[31:16], d[15:0]};
			default: putSized = d;
		endcase
	endfunction

	function automatic logic [31:0] stepOf(input cma_size_t sz);
		unique case (sz)
			CMA_SZ_B: stepOf = `CMA_STEP_B;
			CMA_SZ_W: stepOf = `CMA_STEP_W;
			default: stepOf = `CMA_STEP_L;
		endcase
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [31:0] longReg [8];
	logic [31:0] next_longReg [8];
	cma_state_t state, next_state;
	logic captured, next_captured;
	logic next_modeWide, next_cmdReady, next_done, next_illegalOp, next_powerDown;
	logic [1:0] next_clkSel;
	logic [31:0] next_result, next_pc;
	logic [7:0] condCode, next_condCode;
	cma_mem_req_t next_memReq;
	logic [1:0] pushLeft, next_pushLeft;
	logic isExc, next_isExc;
	logic [31:0] fetchAddr, next_fetchAddr;
	logic [3:0] dstIdx, next_dstIdx;
	logic dstWord, next_dstWord;
	logic take, mulStart, mulDone;
	logic [31:0] mulProduct, mulBFull;
	logic [15:0] mulA, mulB;
	logic [31:0] sp, base, pushStep;

	assign take = cmdValid && cmdReady;
	assign mulStart = take && (cmd.op == CMA_OP_MUL);
	assign sp = longReg[`CMA_SP_INDEX];
	assign base = longReg[cmd.rd[2:0]];
	assign pushStep = modeWide ? `CMA_STEP_L : `CMA_STEP_W;
	assign mulA = (cmd.size == CMA_SZ_B) ? {8'h00, base[7:0]} : base[15:0];
	assign mulBFull = getSized(longReg[cmd.rs[2:0]], cmd.rs, (cmd.size == CMA_SZ_B) ? CMA_SZ_B : CMA_SZ_W);
	assign mulB = mulBFull[15:0];

	cma_mul_unit u_mul (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(mulStart),
		.sgn(cmd.sgn),
		.word(cmd.size != CMA_SZ_B),
		.opA(mulA),
		.opB(mulB),
		.done(mulDone),
		.product(mulProduct)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		next_longReg = longReg;
		next_state = state;
		next_captured = 1'b1;
		next_modeWide = captured ? modeWide : modePin;
		next_done = 1'b0;
		next_illegalOp = 1'b0;
		next_powerDown = powerDown;
		next_clkSel = clkSel;
		next_result = result;
		next_pc = pc;
		next_condCode = condCode;
		next_memReq = memReq;
		next_pushLeft = pushLeft;
		next_isExc = isExc;
		next_fetchAddr = fetchAddr;
		next_dstIdx = dstIdx;
		next_dstWord = dstWord;
		unique case (state)
			CMA_ST_IDLE:
			begin
				if (take)
				begin
					unique case (cmd.op)
						CMA_OP_NOP: next_done = 1'b1;
						CMA_OP_MOVI:
						begin
							// Any half may be written freely, whatever its partner holds
							next_longReg[cmd.rd[2:0]] = putSized(base, cmd.rd, cmd.size, cmd.imm);
							next_done = 1'b1;
						end
						CMA_OP_READ:
						begin
							next_result = getSized(base, cmd.rd, cmd.size);
							next_done = 1'b1;
						end
						CMA_OP_ADDR_DISP:
						begin
							next_result = maskAddr(modeWide, base + cmd.imm);
							next_done = 1'b1;
						end
						CMA_OP_ADDR_POSTINC:
						begin
							next_result = maskAddr(modeWide, base);
							// Full 32-bit update: a carry out of the low half lands in the upper half
							next_longReg[cmd.rd[2:0]] = base + stepOf(cmd.size);
							next_done = 1'b1;
						end
						CMA_OP_ADDR_PREDEC:
						begin
							next_result = maskAddr(modeWide, base - stepOf(cmd.size));
							next_longReg[cmd.rd[2:0]] = base - stepOf(cmd.size);
							next_done = 1'b1;
						end
						CMA_OP_MUL:
						begin
							next_dstIdx = cmd.rd;
							next_dstWord = (cmd.size != CMA_SZ_B);
							next_state = CMA_ST_MUL;
						end
						CMA_OP_JUMP_IND:
						begin
							// A stale exception flag would misclassify this fetch
							next_isExc = 1'b0;
							next_fetchAddr = {24'h000000, cmd.imm[7:0]} & `CMA_IND_AREA_MASK;
							next_memReq = '{req: 1'b1, write: 1'b0, size: modeWide ? CMA_SZ_L : CMA_SZ_W,
								addr: {24'h000000, cmd.imm[7:0]}, wdata: 32'h00000000};
							next_state = CMA_ST_FETCH;
						end
						CMA_OP_CALL_IND, CMA_OP_EXC:
						begin
							next_isExc = (cmd.op == CMA_OP_EXC);
							if (cmd.op == CMA_OP_EXC)
								next_fetchAddr = modeWide ? `CMA_VEC_BASE + {22'h000000, cmd.imm[7:0], 2'h0}
									: `CMA_VEC_BASE + {23'h000000, cmd.imm[7:0], 1'h0};
							else
								next_fetchAddr = {24'h000000, cmd.imm[7:0]};
							// Narrow exceptions need a second word for the condition codes
							next_pushLeft = (cmd.op == CMA_OP_EXC && !modeWide) ? 2'h2 : 2'h1;
							next_longReg[`CMA_SP_INDEX] = sp - pushStep;
							// Wide exception frame packs condition codes above the 24-bit PC
							next_memReq = '{req: 1'b1, write: 1'b1, size: modeWide ? CMA_SZ_L : CMA_SZ_W,
								addr: maskAddr(modeWide, sp - pushStep),
								wdata: modeWide ? {(cmd.op == CMA_OP_EXC) ? condCode : 8'h00, pc[23:0]}
									: {16'h0000, pc[15:0]}};
							next_state = CMA_ST_PUSH;
						end
						CMA_OP_SLEEP:
						begin
							next_powerDown = 1'b1;
							next_clkSel = cmd.imm[1:0];
							next_state = CMA_ST_SLEEP;
						end
						CMA_OP_ACCUM: next_illegalOp = 1'b1;
						CMA_OP_LDPC:
						begin
							next_pc = maskAddr(modeWide, cmd.imm);
							next_done = 1'b1;
						end
						CMA_OP_LDCOND:
						begin
							next_condCode = cmd.imm[7:0];
							next_done = 1'b1;
						end
						default: next_illegalOp = 1'b1;
					endcase
				end
			end
			CMA_ST_MUL:
			begin
				if (mulDone)
				begin
					if (dstWord)
						next_longReg[dstIdx[2:0]] = mulProduct;
					else
						next_longReg[dstIdx[2:0]] = putSized(longReg[dstIdx[2:0]], dstIdx, CMA_SZ_W, mulProduct);
					next_result = mulProduct;
					next_done = 1'b1;
					next_state = CMA_ST_IDLE;
				end
			end
			CMA_ST_PUSH:
			begin
				if (memAck)
				begin
					if (pushLeft == 2'h2)
					begin
						// Only the PC and condition codes are ever stacked
						next_pushLeft = 2'h1;
						next_longReg[`CMA_SP_INDEX] = sp - pushStep;
						next_memReq = '{req: 1'b1, write: 1'b1, size: CMA_SZ_W,
							addr: maskAddr(modeWide, sp - pushStep), wdata: {16'h0000, condCode, condCode}};
					end
					else
					begin
						next_pushLeft = 2'h0;
						next_memReq = '{req: 1'b1, write: 1'b0, size: modeWide ? CMA_SZ_L : CMA_SZ_W,
							addr: fetchAddr, wdata: 32'h00000000};
						next_state = CMA_ST_FETCH;
					end
				end
			end
			CMA_ST_FETCH:
			begin
				if (memAck)
				begin
					next_memReq.req = 1'b0;
					next_pc = maskAddr(modeWide, memRdata);
					next_result = maskAddr(modeWide, memRdata);
					next_done = 1'b1;
					next_state = CMA_ST_IDLE;
				end
			end
			CMA_ST_SLEEP:
			begin
				if (wake)
				begin
					next_powerDown = 1'b0;
					next_done = 1'b1;
					next_state = CMA_ST_IDLE;
				end
			end
			default: next_state = CMA_ST_IDLE;
		endcase
		next_cmdReady = captured && (next_state == CMA_ST_IDLE);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 8; i++)
				longReg[i] <= `CMA_REG_RESET;
			state <= CMA_ST_IDLE;
			captured <= 1'b0;
			modeWide <= 1'b0;
			cmdReady <= 1'b0;
			done <= 1'b0;
			illegalOp <= 1'b0;
			powerDown <= 1'b0;
			clkSel <= `CMA_CLKSEL_RESET;
			result <= 32'h00000000;
			pc <= `CMA_PC_RESET;
			condCode <= `CMA_COND_RESET;
			memReq <= '0;
			pushLeft <= 2'h0;
			isExc <= 1'b0;
			fetchAddr <= 32'h00000000;
			dstIdx <= 4'h0;
			dstWord <= 1'b0;
		end
		else
		begin
			longReg <= next_longReg;
			state <= next_state;
			captured <= next_captured;
			modeWide <= next_modeWide;
			cmdReady <= next_cmdReady;
			done <= next_done;
			illegalOp <= next_illegalOp;
			powerDown <= next_powerDown;
			clkSel <= next_clkSel;
			result <= next_result;
			pc <= next_pc;
			condCode <= next_condCode;
			memReq <= next_memReq;
			pushLeft <= next_pushLeft;
			isExc <= next_isExc;
			fetchAddr <= next_fetchAddr;
			dstIdx <= next_dstIdx;
			dstWord <= next_dstWord;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	a_narrow_addr_width: assert property (memReq.req && !modeWide |-> memReq.addr[31:16] == 16'h0000)
		else $error("narrow address above 64 kbytes");
	a_wide_addr_width: assert property (memReq.req |-> memReq.addr[31:24] == 8'h00)
		else $error("address above 16 Mbytes");
	a_pc_top_byte: assert property (pc[31:24] == 8'h00 && (modeWide || pc[31:16] == 16'h0000))
		else $error("branch target has nonzero upper bits");
	a_mode_held: assert property (captured |=> $stable(modeWide))
		else $error("mode changed after capture");
	a_mulu_byte_states: assert property (take && cmd.op == CMA_OP_MUL && !cmd.sgn && cmd.size == CMA_SZ_B
		|-> !done [*8] ##1 !done [*4] ##1 done)
		else $error("unsigned byte multiply not 12 states");
	a_muls_byte_states: assert property (take && cmd.op == CMA_OP_MUL && cmd.sgn && cmd.size == CMA_SZ_B
		|-> ##13 done)
		else $error("signed byte multiply not 13 states");
	a_mulu_word_states: assert property (take && cmd.op == CMA_OP_MUL && !cmd.sgn && cmd.size != CMA_SZ_B
		|-> ##20 done)
		else $error("unsigned word multiply not 20 states");
	a_muls_word_states: assert property (take && cmd.op == CMA_OP_MUL && cmd.sgn && cmd.size != CMA_SZ_B
		|-> ##21 done)
		else $error("signed word multiply not 21 states");
	a_simple_one_state: assert property (take && cmd.op == CMA_OP_MOVI |=> done && cmdReady)
		else $error("register load not single state");
	a_accum_refused: assert property (take && cmd.op == CMA_OP_ACCUM |=> illegalOp && !done)
		else $error("accumulator instruction accepted");
	a_sleep_entry: assert property (take && cmd.op == CMA_OP_SLEEP
		|=> powerDown && clkSel == $past(cmd.imm[1:0]))
		else $error("sleep did not enter power-down");
	a_vec_narrow_addr: assert property (state == CMA_ST_FETCH && isExc && !modeWide && memReq.req
		|-> memReq.addr[0] == 1'b0 && memReq.addr[31:9] == 23'h000000)
		else $error("narrow vector fetch misplaced");
	a_vec_wide_addr: assert property (state == CMA_ST_FETCH && isExc && modeWide && memReq.req
		|-> memReq.addr[1:0] == 2'h0 && memReq.size == CMA_SZ_L)
		else $error("wide vector fetch misplaced");
	a_postinc_carry: assert property (take && cmd.op == CMA_OP_ADDR_POSTINC && cmd.size == CMA_SZ_W
		&& base[15:0] >= 16'hFFFE |=> longReg[$past(cmd.rd[2:0])][31:16] == $past(base[31:16]) + 16'h0001)
		else $error("post-increment carry lost");
	a_push_count: assert property (take && cmd.op == CMA_OP_CALL_IND |=> memReq.write && memReq.req
		&& longReg[`CMA_SP_INDEX] == $past(sp) - $past(pushStep))
		else $error("call push wrong");

	c_multiply: cover property (take && cmd.op == CMA_OP_MUL ##[1:25] done);
	c_call_indirect: cover property (take && cmd.op == CMA_OP_CALL_IND ##[1:40] done);
	c_exception_narrow: cover property (take && cmd.op == CMA_OP_EXC && !modeWide ##[1:60] done);
	c_sleep_wake: cover property (take && cmd.op == CMA_OP_SLEEP ##[1:50] done);

endmodule // cma_core

`default_nettype wire

/* File: src/cma_consts.svh */
`ifndef CMA_CONSTS_SVH
`define CMA_CONSTS_SVH

// ****************************************************************
// Address masks and layout
// ****************************************************************
`define CMA_NARROW_ADDR_MASK 32'h0000FFFF
`define CMA_WIDE_ADDR_MASK 32'h00FFFFFF
`define CMA_VEC_BASE 32'h00000000
`define CMA_IND_AREA_MASK 32'h000000FF
`define CMA_SP_INDEX 3'h7
`define CMA_STEP_B 32'h00000001
`define CMA_STEP_W 32'h00000002
`define CMA_STEP_L 32'h00000004

// ****************************************************************
// Reset values
// ****************************************************************
`define CMA_PC_RESET 32'h00000000
`define CMA_COND_RESET 8'h80
`define CMA_REG_RESET 32'h00000000
`define CMA_CLKSEL_RESET 2'h0

// ****************************************************************
// Multiply state counts
// ****************************************************************
`define CMA_MULU_B_STATES 5'h0C
`define CMA_MULU_W_STATES 5'h14
`define CMA_MULS_B_STATES 5'h0D
`define CMA_MULS_W_STATES 5'h15

`endif

/* File: src/cma_pkg.sv */
package cma_pkg;

	typedef enum logic [3:0] {
		CMA_OP_NOP = 4'h0,
		CMA_OP_MOVI = 4'h1,
		CMA_OP_READ = 4'h2,
		CMA_OP_ADDR_DISP = 4'h3,
		CMA_OP_ADDR_POSTINC = 4'h4,
		CMA_OP_ADDR_PREDEC = 4'h5,
		CMA_OP_MUL = 4'h6,
		CMA_OP_JUMP_IND = 4'h7,
		CMA_OP_CALL_IND = 4'h8,
		CMA_OP_EXC = 4'h9,
		CMA_OP_SLEEP = 4'hA,
		CMA_OP_ACCUM = 4'hB,
		CMA_OP_LDPC = 4'hC,
		CMA_OP_LDCOND = 4'hD
	} cma_op_t;

	typedef enum logic [1:0] {
		CMA_SZ_B = 2'h0,
		CMA_SZ_W = 2'h1,
		CMA_SZ_L = 2'h2
	} cma_size_t;

	typedef enum logic [2:0] {
		CMA_ST_IDLE = 3'h0,
		CMA_ST_MUL = 3'h1,
		CMA_ST_PUSH = 3'h2,
		CMA_ST_FETCH = 3'h3,
		CMA_ST_SLEEP = 3'h4
	} cma_state_t;

	typedef struct packed {
		cma_op_t op;
		cma_size_t size;
		logic sgn;
		logic [3:0] rd;
		logic [3:0] rs;
		logic [31:0] imm;
	} cma_cmd_t;

	typedef struct packed {
		logic req;
		logic write;
		cma_size_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cma_mem_req_t;

endpackage

/* File: src/cma_mul_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cma_consts.svh"

module cma_mul_unit
	import cma_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Request
	input wire logic start,
	input wire logic sgn,
	input wire logic word,
	input wire logic [15:0] opA,
	input wire logic [15:0] opB,
	// Answer
	output logic done,
	output logic [31:0] product
);

	logic [4:0] cnt, next_cnt;
	logic running, next_running;
	logic next_done;
	logic [31:0] next_product;
	logic sgnQ, next_sgnQ;
	logic wordQ, next_wordQ;
	logic [15:0] aQ, next_aQ;
	logic [15:0] bQ, next_bQ;
	logic [16:0] extA, extB;
	logic signed [33:0] full;

	// Sign or zero extension to a common 17-bit signed form
	always_comb
	begin
		extA = wordQ ? {sgnQ & aQ[15], aQ} : {{9{sgnQ & aQ[7]}}, aQ[7:0]};
		extB = wordQ ? {sgnQ & bQ[15], bQ} : {{9{sgnQ & bQ[7]}}, bQ[7:0]};
		full = $signed(extA) * $signed(extB);
	end

	// Count leaves two states for the issue edge and the write-back edge
	always_comb
	begin
		next_cnt = cnt;
		next_running = running;
		next_done = 1'b0;
		next_product = product;
		next_sgnQ = sgnQ;
		next_wordQ = wordQ;
		next_aQ = aQ;
		next_bQ = bQ;
		if (start)
		begin
			next_running = 1'b1;
			next_sgnQ = sgn;
			next_wordQ = word;
			next_aQ = opA;
			next_bQ = opB;
			if (word)
				next_cnt = (sgn ? `CMA_MULS_W_STATES : `CMA_MULU_W_STATES) - 5'h02;
			else
				next_cnt = (sgn ? `CMA_MULS_B_STATES : `CMA_MULU_B_STATES) - 5'h02;
		end
		else if (running)
		begin
			if (cnt == 5'h01)
			begin
				next_running = 1'b0;
				next_done = 1'b1;
				next_product = full[31:0];
			end
			else
				next_cnt = cnt - 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 5'h00;
			running <= 1'b0;
			done <= 1'b0;
			product <= 32'h00000000;
			sgnQ <= 1'b0;
			wordQ <= 1'b0;
			aQ <= 16'h0000;
			bQ <= 16'h0000;
		end
		else
		begin
			cnt <= next_cnt;
			running <= next_running;
			done <= next_done;
			product <= next_product;
			sgnQ <= next_sgnQ;
			wordQ <= next_wordQ;
			aQ <= next_aQ;
			bQ <= next_bQ;
		end
	end

endmodule // cma_mul_unit

`default_nettype wire

/* File: test/cma_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

module cma_mem_model
	import cma_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Memory port
	input wire cma_pkg::cma_mem_req_t memReq,
	output logic memAck,
	output logic [31:0] memRdata,
	// Answer speed
	input wire logic [3:0] ackDelay
);
	import cma_pkg::*;

	// ****************************************************************
	// Storage and write log
	// ****************************************************************
	logic [7:0] mem [0:8191];
	logic [31:0] wrAddr [$];
	logic [31:0] wrData [$];
	logic [31:0] rdWord;
	logic [3:0] waitCnt;
	logic [12:0] a;
	int nb;

	// ****************************************************************
	// Answer after ackDelay idle cycles, one-cycle acknowledge
	// ****************************************************************
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			memAck <= 1'b0;
			waitCnt <= 4'h0;
			memRdata <= 32'h5A5A5A5A;
		end
		else
		begin
			memAck <= 1'b0;
			// Read data is only valid with the acknowledge, so it churns otherwise
			memRdata <= ~memRdata;
			if (memReq.req && !memAck)
			begin
				if (waitCnt < ackDelay)
					waitCnt <= waitCnt + 4'h1;
				else
				begin
					waitCnt <= 4'h0;
					memAck <= 1'b1;
					a = memReq.addr[12:0];
					nb = (memReq.size == CMA_SZ_L) ? 4 : (memReq.size == CMA_SZ_W) ? 2 : 1;
					rdWord = 32'h00000000;
					for (int i = 0; i < nb; i++)
					begin
						if (memReq.write)
							mem[a + i] = 8'(memReq.wdata >> (8 * (nb - 1 - i)));
						rdWord = {rdWord[23:0], mem[a + i]};
					end
					if (memReq.write)
					begin
						wrAddr.push_back(memReq.addr);
						wrData.push_back(memReq.wdata);
					end
					else
						memRdata <= rdWord;
				end
			end
		end
	end
endmodule // cma_mem_model

`default_nettype wire

/* File: test/cma_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module cma_core_tb;
	import cma_pkg::*;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic modePin = 1'b0;
	logic cmdValid = 1'b0;
	logic wake = 1'b0;
	logic [3:0] ackDelay = 4'h0;
	cma_cmd_t cmd = '0;
	cma_mem_req_t memReq;
	logic cmdReady, done, illegalOp, memAck, powerDown, modeWide, ill;
	logic [31:0] result, memRdata, pc;
	logic [1:0] clkSel;
	int fails = 0;
	int checked = 0;
	int cyc;

	always #5 mclk = ~mclk;

	cma_core u_cma_core (.mclk(mclk), .arst_n(arst_n), .modePin(modePin), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .done(done), .illegalOp(illegalOp), .result(result), .memReq(memReq),
		.memAck(memAck), .memRdata(memRdata), .wake(wake), .powerDown(powerDown), .clkSel(clkSel),
		.modeWide(modeWide), .pc(pc));
	cma_mem_model u_cma_mem_model (.mclk(mclk), .arst_n(arst_n), .memReq(memReq), .memAck(memAck),
		.memRdata(memRdata), .ackDelay(ackDelay));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic hang(input string what);
		fails++;
		$display("[FAIL] %0t no answer: %s", $time, what);
		stop_test;
	endtask

	task automatic reset_to(input logic mode);
		arst_n <= 1'b0;
		modePin <= mode;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	// Holds the command until the take edge, then counts edges up to done or refusal
	task automatic run(input cma_op_t op, input cma_size_t sz, input logic sg, input logic [3:0] r,
		input logic [31:0] im);
		cmdValid <= 1'b1;
		// A multiply takes its source index from imm, which it otherwise ignores
		cmd <= '{op: op, size: sz, sgn: sg, rd: r, rs: (op == CMA_OP_MUL) ? im[3:0] : r, imm: im};
		cyc = 0;
		do
		begin
			@(posedge mclk);
			if (++cyc > 100)
				hang("ready");
		end
		while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		cyc = 0;
		do
		begin
			@(posedge mclk);
			if (++cyc > 200)
				hang("done");
		end
		while (done !== 1'b1 && illegalOp !== 1'b1);
		ill = illegalOp;
	endtask

	task automatic poke(input int a, input logic [31:0] v, input int nb);
		for (int i = 0; i < nb; i++)
			u_cma_mem_model.mem[a + i] = 8'(v >> (8 * (nb - 1 - i)));
		u_cma_mem_model.wrAddr.delete();
		u_cma_mem_model.wrData.delete();
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_narrow_ea;
		chk(modeWide, 0, "narrow mode");
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h3, 32'h0000FFFF);
		run(CMA_OP_ADDR_POSTINC, CMA_SZ_W, 1'b0, 4'h3, 32'h0);
		chk(result, 32'h0000FFFF, "postinc addr");
		chk(32'(cyc), 1, "one state");
		run(CMA_OP_MOVI, CMA_SZ_B, 1'b0, 4'hB, 32'h00000077);
		run(CMA_OP_READ, CMA_SZ_L, 1'b0, 4'h3, 32'h0);
		chk(result, 32'h00010077, "carry and byte");
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h4, 32'h00010000);
		run(CMA_OP_ADDR_PREDEC, CMA_SZ_W, 1'b0, 4'h4, 32'h0);
		chk(result, 32'h0000FFFE, "predec addr");
		run(CMA_OP_READ, CMA_SZ_L, 1'b0, 4'h4, 32'h0);
		chk(result, 32'h0000FFFE, "borrow");
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h5, 32'h1234FFF0);
		run(CMA_OP_ADDR_DISP, CMA_SZ_W, 1'b0, 4'h5, 32'h00000020);
		chk(result, 32'h00000010, "disp addr");
		run(CMA_OP_READ, CMA_SZ_L, 1'b0, 4'h5, 32'h0);
		chk(result, 32'h1234FFF0, "upper half");
	endtask

	task automatic t_mul;
		logic [31:0] expP [4] = '{32'h00000EF1, 32'hFFFFFFF1, 32'h000EFFF1, 32'hFFFFFFF1};
		int expN [4] = '{12, 13, 20, 21};
		for (int k = 0; k < 4; k++)
		begin
			run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h1, 32'h0000000F);
			run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h2, 32'h0000FFFF);
			// Source is the low byte or the lower word of the second register
			run(CMA_OP_MUL, k[1] ? CMA_SZ_W : CMA_SZ_B, k[0], 4'h1, k[1] ? 32'h00000002 : 32'h0000000A);
			chk(32'(cyc), 32'(expN[k]), "mul states");
			chk(result, expP[k], "product");
		end
	endtask

	task automatic t_branch_narrow;
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h7, 32'h00001000);
		run(CMA_OP_LDPC, CMA_SZ_L, 1'b0, 4'h0, 32'h00001234);
		poke(32'h40, 32'h0000BEEF, 2);
		ackDelay <= 4'h3;
		run(CMA_OP_CALL_IND, CMA_SZ_W, 1'b0, 4'h0, 32'h00000040);
		chk(32'(u_cma_mem_model.wrAddr.size()), 1, "call pushes");
		chk(u_cma_mem_model.wrAddr[0], 32'h00000FFE, "call push addr");
		chk(u_cma_mem_model.wrData[0] & 32'h0000FFFF, 32'h00001234, "call push pc");
		chk(pc, 32'h0000BEEF, "indirect target");
		ackDelay <= 4'h0;
		poke(32'h6, 32'h00000ABC, 2);
		run(CMA_OP_EXC, CMA_SZ_W, 1'b0, 4'h0, 32'h00000003);
		chk(32'(u_cma_mem_model.wrAddr.size()), 2, "exception pushes");
		chk(u_cma_mem_model.wrAddr[0], 32'h00000FFC, "pc push addr");
		chk(u_cma_mem_model.wrData[0] & 32'h0000FFFF, 32'h0000BEEF, "pc push");
		chk(u_cma_mem_model.wrAddr[1], 32'h00000FFA, "cond push addr");
		chk(pc, 32'h00000ABC, "narrow vector");
	endtask

	task automatic t_sleep_refuse;
		run(CMA_OP_ACCUM, CMA_SZ_L, 1'b0, 4'h0, 32'h0);
		chk(ill, 1, "accum refused");
		chk(done, 0, "accum no done");
		fork
			run(CMA_OP_SLEEP, CMA_SZ_B, 1'b0, 4'h0, 32'h00000002);
			begin
				repeat (3) @(posedge mclk);
				chk(powerDown, 1, "sleeping");
				chk(clkSel, 2, "clock select");
				chk(cmdReady, 0, "busy in sleep");
				wake <= 1'b1;
				@(posedge mclk);
				wake <= 1'b0;
			end
		join
		chk(32'(cyc), 4, "wake timing");
		chk(powerDown, 0, "awake");
	endtask

	task automatic t_wide;
		reset_to(1'b1);
		chk(modeWide, 1, "wide mode");
		modePin <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(modeWide, 1, "mode held");
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h5, 32'h1234FFF0);
		run(CMA_OP_ADDR_DISP, CMA_SZ_L, 1'b0, 4'h5, 32'h00000020);
		chk(result, 32'h00350010, "wide addr");
		run(CMA_OP_MOVI, CMA_SZ_L, 1'b0, 4'h7, 32'h00002000);
		poke(32'h80, 32'hAB654321, 4);
		run(CMA_OP_JUMP_IND, CMA_SZ_L, 1'b0, 4'h0, 32'h00000080);
		chk(pc, 32'h00654321, "wide indirect");
		poke(32'h8, 32'hFF111111, 4);
		run(CMA_OP_EXC, CMA_SZ_L, 1'b0, 4'h0, 32'h00000002);
		chk(pc, 32'h00111111, "wide vector");
		chk(32'(u_cma_mem_model.wrAddr.size()), 1, "wide pushes");
		chk(u_cma_mem_model.wrAddr[0], 32'h00001FFC, "wide push addr");
		chk(u_cma_mem_model.wrData[0] & 32'h00FFFFFF, 32'h00654321, "wide push pc");
	endtask

	initial
	begin
		reset_to(1'b0);
		t_narrow_ea;
		t_mul;
		t_branch_narrow;
		t_sleep_refuse;
		t_wide;
		stop_test;
	end
endmodule // cma_core_tb

`default_nettype wire
